// *** common/isfm_regs.vh ***
// constants for the interrupt source flag map
`ifndef ISFM_REGS_VH
`define ISFM_REGS_VH

// maskable sources, indexed by default order (0 highest)
`define ISFM_NUM_SRC      51
`define ISFM_LAST_SRC     50
`define ISFM_IDX_W        6

// shared or special slots in default order
`define ISFM_SLOT_VOLT    1
`define ISFM_SLOT_PIN0    2
`define ISFM_SLOT_SER2    8
`define ISFM_SLOT_SER0    11
`define ISFM_SLOT_U0ERR   14
`define ISFM_SLOT_SER1    15
`define ISFM_SLOT_U1ERR   17
`define ISFM_SLOT_CORR    19
`define ISFM_SLOT_PERIOD  24
`define ISFM_SLOT_PIN6    30
`define ISFM_SLOT_PIN7    31
`define ISFM_SLOT_XUERR   50

// vector words
`define ISFM_VEC_RESET    16'h0000
`define ISFM_VEC_TRAP     16'h007E
`define ISFM_VEC_XUERR    16'h0072

// vector word = 2 * order + segment offset
`define ISFM_SEG1_END     10
`define ISFM_SEG2_END     19
`define ISFM_SEG3_END     31
`define ISFM_SEG4_END     40
`define ISFM_SEG1_OFS     16'h0004
`define ISFM_SEG2_OFS     16'h0008
`define ISFM_SEG3_OFS     16'h000A
`define ISFM_SEG4_OFS     16'h000C
`define ISFM_SEG5_OFS     16'h000E

// detector mode select position in the detection level register
`define ISFM_MODE_BIT     7
`define ISFM_OPC_ILLEGAL  8'hFF

// flag write select
`define ISFM_SEL_REQ      2'h0
`define ISFM_SEL_MASK     2'h1
`define ISFM_SEL_LVL0     2'h2
`define ISFM_SEL_LVL1     2'h3

// reset cause bit positions
`define ISFM_RC_PIN       0
`define ISFM_RC_POR       1
`define ISFM_RC_VOLT      2
`define ISFM_RC_WDT       3
`define ISFM_RC_OPC       4
`define ISFM_RC_ACCESS    5
`define ISFM_RC_PARITY    6
`define ISFM_RC_W         7

`endif

// *** core/isfm_edge.v ***
// external pin edge detector with separate rise and fall enables
`default_nettype none
module isfm_edge (
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire [7:0] extPin,
  input  wire [7:0] riseEdgeEnableReg,
  input  wire [7:0] fallEdgeEnableReg,
  output wire [7:0] pinEvent
);
  reg [7:0] pinPrev_ff;
  reg [7:0] pinEvent_ff;
  wire [7:0] nxt_pinEvent;

  assign nxt_pinEvent = (extPin & ~pinPrev_ff & riseEdgeEnableReg) |
                        (~extPin & pinPrev_ff & fallEdgeEnableReg);

  // loading the pin level in reset avoids a false edge on release
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      pinPrev_ff  <= extPin;
      pinEvent_ff <= 8'h00;
    end else begin
      pinPrev_ff  <= extPin;
      pinEvent_ff <= nxt_pinEvent;
    end
  end

  assign pinEvent = pinEvent_ff;
endmodule
`default_nettype wire

// *** core/isfm_core.v ***
// vectored interrupt request flags, arbitration, trap and reset sources
`include "isfm_regs.vh"
`default_nettype none
// Overview of operation
// - equal level: lowest default order wins
// - extra uart error: order 50, vector 0072
// - software trap uses vector 007E
// - every reset source uses vector 0000
// - mode bit 1: voltage event resets
// - opcode FF triggers illegal-instruction reset
// - no illegal-instruction reset under debug
// - each source: request, mask, two level bits
// - serial2 three ends share slot 8
// - serial0 three ends share slot 11
// - uart0 error and timer1 upper share
// - serial1 three ends share slot 15
// - uart1 error and timer3 upper share
// - pin edges selected by rise/fall enables
// - mode bit 0: voltage event interrupts
// - acknowledge clears the request flag
// - mask 0 enables, mask 1 blocks
// - trap ignores global enable and levels
module isfm_core (
  input  wire                     ref_clk,
  input  wire                     reset_n,
  input  wire [`ISFM_LAST_SRC:0]  periphReq,
  input  wire                     serial2TxEndIrq,
  input  wire                     serial2ClockedEndIrq,
  input  wire                     serial2SimpleI2cIrq,
  input  wire                     serial0TxEndIrq,
  input  wire                     serial0ClockedEndIrq,
  input  wire                     serial0SimpleI2cIrq,
  input  wire                     serial1TxEndIrq,
  input  wire                     serial1ClockedEndIrq,
  input  wire                     serial1SimpleI2cIrq,
  input  wire                     uart0RxErrorIrq,
  input  wire                     timerCh1UpperIrq,
  input  wire                     uart1RxErrorIrq,
  input  wire                     timerCh3UpperIrq,
  input  wire                     clockCorrectionIrq,
  input  wire                     samplingDetect0Irq,
  input  wire                     clockPeriodicAlarmIrq,
  input  wire                     samplingDetect1Irq,
  input  wire                     extraUartRxErrorIrq,
  input  wire [7:0]               extPin,
  input  wire [7:0]               riseEdgeEnableReg,
  input  wire [7:0]               fallEdgeEnableReg,
  input  wire [7:0]               detectionLevelReg,
  input  wire                     voltageDetect,
  input  wire                     resetPin,
  input  wire                     powerOnReset,
  input  wire                     watchdogOverflow,
  input  wire                     opcodeExec,
  input  wire [7:0]               opcodeByte,
  input  wire                     debugMode,
  input  wire                     illegalAccessReset,
  input  wire                     ramParityReset,
  input  wire                     softwareTrapInstruction,
  input  wire                     trapAck,
  input  wire                     globalIrqEnable,
  input  wire                     inServiceLevelBit0,
  input  wire                     inServiceLevelBit1,
  input  wire                     irqAck,
  input  wire                     flagWrEn,
  input  wire [1:0]               flagWrSel,
  input  wire [`ISFM_IDX_W-1:0]   flagWrIdx,
  input  wire                     flagWrData,
  output wire [`ISFM_LAST_SRC:0]  reqFlags,
  output wire [`ISFM_LAST_SRC:0]  maskFlags,
  output wire [`ISFM_LAST_SRC:0]  levelBit0Flags,
  output wire [`ISFM_LAST_SRC:0]  levelBit1Flags,
  output wire                     irqReq,
  output wire [15:0]              irqVector,
  output wire [1:0]               irqLevel,
  output wire [`ISFM_IDX_W-1:0]   irqIndex,
  output wire                     trapReq,
  output wire [15:0]              trapVector,
  output wire                     resetReq,
  output wire [`ISFM_RC_W-1:0]    resetCause,
  output wire [15:0]              resetVector
);
  reg [`ISFM_LAST_SRC:0]  req_ff;
  reg [`ISFM_LAST_SRC:0]  mask_ff;
  reg [`ISFM_LAST_SRC:0]  lvl0_ff;
  reg [`ISFM_LAST_SRC:0]  lvl1_ff;
  reg [`ISFM_LAST_SRC:0]  nxt_req;
  reg [`ISFM_LAST_SRC:0]  nxt_mask;
  reg [`ISFM_LAST_SRC:0]  nxt_lvl0;
  reg [`ISFM_LAST_SRC:0]  nxt_lvl1;
  reg [`ISFM_LAST_SRC:0]  srcSet;
  reg                     irqReq_ff;
  reg [15:0]              irqVector_ff;
  reg [1:0]               irqLevel_ff;
  reg [`ISFM_IDX_W-1:0]   irqIndex_ff;
  reg                     nxt_irqReq;
  reg [1:0]               nxt_irqLevel;
  reg [`ISFM_IDX_W-1:0]   nxt_irqIndex;
  reg                     trapReq_ff;
  reg                     resetReq_ff;
  reg [`ISFM_RC_W-1:0]    resetCause_ff;
  reg [`ISFM_RC_W-1:0]    rstSrc;
  wire [7:0]              pinEvent;
  wire                    modeSelect;
  wire                    anyRst;
  wire [1:0]              serviceLevel;
  integer                 i;

  // vector word from default order
  function [15:0] vec_of;
    input [`ISFM_IDX_W-1:0] idx;
    reg   [15:0]            dbl;
    begin
      dbl = {9'h000, idx, 1'b0};
      if (idx <= `ISFM_SEG1_END)
        vec_of = dbl + `ISFM_SEG1_OFS;
      else if (idx <= `ISFM_SEG2_END)
        vec_of = dbl + `ISFM_SEG2_OFS;
      else if (idx <= `ISFM_SEG3_END)
        vec_of = dbl + `ISFM_SEG3_OFS;
      else if (idx <= `ISFM_SEG4_END)
        vec_of = dbl + `ISFM_SEG4_OFS;
      else
        vec_of = dbl + `ISFM_SEG5_OFS;
    end
  endfunction

  isfm_edge u_edge (
    .ref_clk           (ref_clk),
    .reset_n           (reset_n),
    .extPin            (extPin),
    .riseEdgeEnableReg (riseEdgeEnableReg),
    .fallEdgeEnableReg (fallEdgeEnableReg),
    .pinEvent          (pinEvent)
  );

  assign modeSelect   = detectionLevelReg[`ISFM_MODE_BIT];
  assign serviceLevel = {inServiceLevelBit1, inServiceLevelBit0};

  // reset source collection
  always @* begin
    rstSrc = {`ISFM_RC_W{1'b0}};
    rstSrc[`ISFM_RC_PIN]    = resetPin;
    rstSrc[`ISFM_RC_POR]    = powerOnReset;
    // voltage reset when mode is 1
    rstSrc[`ISFM_RC_VOLT]   = voltageDetect & modeSelect;
    rstSrc[`ISFM_RC_WDT]    = watchdogOverflow;
    rstSrc[`ISFM_RC_OPC]    = opcodeExec & (opcodeByte == `ISFM_OPC_ILLEGAL) & ~debugMode;
    rstSrc[`ISFM_RC_ACCESS] = illegalAccessReset;
    rstSrc[`ISFM_RC_PARITY] = ramParityReset;
  end

  assign anyRst = |rstSrc;

  // hardware request events mapped onto flag slots
  always @* begin
    srcSet = periphReq;
    // voltage interrupt when mode is 0
    srcSet[`ISFM_SLOT_VOLT]   = voltageDetect & ~modeSelect;
    srcSet[`ISFM_SLOT_PIN0+5:`ISFM_SLOT_PIN0] = pinEvent[5:0];
    srcSet[`ISFM_SLOT_PIN6]   = pinEvent[6];
    srcSet[`ISFM_SLOT_PIN7]   = pinEvent[7];
    srcSet[`ISFM_SLOT_SER2]   = serial2TxEndIrq | serial2ClockedEndIrq | serial2SimpleI2cIrq;
    srcSet[`ISFM_SLOT_SER0]   = serial0TxEndIrq | serial0ClockedEndIrq | serial0SimpleI2cIrq;
    srcSet[`ISFM_SLOT_U0ERR]  = uart0RxErrorIrq | timerCh1UpperIrq;
    srcSet[`ISFM_SLOT_SER1]   = serial1TxEndIrq | serial1ClockedEndIrq | serial1SimpleI2cIrq;
    srcSet[`ISFM_SLOT_U1ERR]  = uart1RxErrorIrq | timerCh3UpperIrq;
    // sharing both events in one flag is harmless only if software keeps one idle
    srcSet[`ISFM_SLOT_CORR]   = clockCorrectionIrq | samplingDetect0Irq;
    srcSet[`ISFM_SLOT_PERIOD] = clockPeriodicAlarmIrq | samplingDetect1Irq;
    // extra uart error at lowest order
    srcSet[`ISFM_SLOT_XUERR]  = extraUartRxErrorIrq;
  end

  // next flag values: clears first, then hardware sets so sets win; a reset source defaults all flags last
  always @* begin
    nxt_req  = req_ff;
    nxt_mask = mask_ff;
    nxt_lvl0 = lvl0_ff;
    nxt_lvl1 = lvl1_ff;
    if (flagWrEn && flagWrIdx <= `ISFM_LAST_SRC) begin
      case (flagWrSel)
        `ISFM_SEL_REQ:  nxt_req[flagWrIdx]  = flagWrData;
        `ISFM_SEL_MASK: nxt_mask[flagWrIdx] = flagWrData;
        `ISFM_SEL_LVL0: nxt_lvl0[flagWrIdx] = flagWrData;
        `ISFM_SEL_LVL1: nxt_lvl1[flagWrIdx] = flagWrData;
        default:        nxt_req = req_ff;
      endcase
    end
    if (irqAck && irqReq_ff)
      nxt_req[irqIndex_ff] = 1'b0;
    nxt_req = nxt_req | srcSet;
    if (anyRst) begin
      nxt_req  = {`ISFM_NUM_SRC{1'b0}};
      nxt_mask = {`ISFM_NUM_SRC{1'b1}};
      nxt_lvl0 = {`ISFM_NUM_SRC{1'b1}};
      nxt_lvl1 = {`ISFM_NUM_SRC{1'b1}};
    end
  end

  // arbitration over the values the flags are about to take
  always @* begin
    nxt_irqReq   = 1'b0;
    nxt_irqLevel = 2'h3;
    nxt_irqIndex = {`ISFM_IDX_W{1'b0}};
    // descending scan so lower order wins ties
    for (i = `ISFM_LAST_SRC; i >= 0; i = i - 1) begin
      if (nxt_req[i] && !nxt_mask[i] && globalIrqEnable &&
          {nxt_lvl1[i], nxt_lvl0[i]} <= serviceLevel &&
          (!nxt_irqReq || {nxt_lvl1[i], nxt_lvl0[i]} <= nxt_irqLevel)) begin
        nxt_irqReq   = 1'b1;
        nxt_irqLevel = {nxt_lvl1[i], nxt_lvl0[i]};
        nxt_irqIndex = i[`ISFM_IDX_W-1:0];
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      req_ff        <= {`ISFM_NUM_SRC{1'b0}};
      mask_ff       <= {`ISFM_NUM_SRC{1'b1}};
      lvl0_ff       <= {`ISFM_NUM_SRC{1'b1}};
      lvl1_ff       <= {`ISFM_NUM_SRC{1'b1}};
      irqReq_ff     <= 1'b0;
      irqVector_ff  <= 16'h0000;
      irqLevel_ff   <= 2'h3;
      irqIndex_ff   <= {`ISFM_IDX_W{1'b0}};
      trapReq_ff    <= 1'b0;
      resetReq_ff   <= 1'b0;
      resetCause_ff <= {`ISFM_RC_W{1'b0}};
    end else begin
      req_ff        <= nxt_req;
      mask_ff       <= nxt_mask;
      lvl0_ff       <= nxt_lvl0;
      lvl1_ff       <= nxt_lvl1;
      irqReq_ff     <= nxt_irqReq;
      irqVector_ff  <= vec_of(nxt_irqIndex);
      irqLevel_ff   <= nxt_irqLevel;
      irqIndex_ff   <= nxt_irqIndex;
      if (softwareTrapInstruction)
        trapReq_ff <= 1'b1;
      else if (trapAck)
        trapReq_ff <= 1'b0;
      resetReq_ff   <= anyRst;
      resetCause_ff <= rstSrc;
    end
  end

  assign reqFlags       = req_ff;
  assign maskFlags      = mask_ff;
  assign levelBit0Flags = lvl0_ff;
  assign levelBit1Flags = lvl1_ff;
  assign irqReq         = irqReq_ff;
  assign irqVector      = irqVector_ff;
  assign irqLevel       = irqLevel_ff;
  assign irqIndex       = irqIndex_ff;
  assign trapReq        = trapReq_ff;
  assign trapVector     = `ISFM_VEC_TRAP;
  assign resetReq       = resetReq_ff;
  assign resetCause     = resetCause_ff;
  assign resetVector    = `ISFM_VEC_RESET;
endmodule
`default_nettype wire

// *** sim/isfm_cpu_model.sv ***
// cpu side model that acknowledges presented interrupts and traps
`default_nettype none
module isfm_cpu_model (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic ackOn,
  input  wire logic irqReq,
  input  wire logic trapReq,
  output var  logic irqAck,
  output var  logic trapAck
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    irqAck = 1'b0;
    trapAck = 1'b0;
  end
  // ack every other cycle so a request not yet withdrawn is never taken twice
  always @(posedge ref_clk) begin
    irqAck <= reset_n && ackOn && irqReq && !irqAck;
    trapAck <= reset_n && ackOn && trapReq && !trapAck;
  end
endmodule
`default_nettype wire

// *** sim/isfm_core_asserts.sv ***
// concurrent checks on the ports of the interrupt source flag map
`default_nettype none
module isfm_core_asserts (
  input wire logic        ref_clk, reset_n, globalIrqEnable, debugMode, opcodeExec,
  input wire logic        voltageDetect, softwareTrapInstruction, irqReq, trapReq, resetReq,
  input wire logic        inServiceLevelBit0, inServiceLevelBit1,
  input wire logic [7:0]  opcodeByte, detectionLevelReg,
  input wire logic [50:0] reqFlags, maskFlags, levelBit0Flags, levelBit1Flags,
  input wire logic [5:0]  irqIndex,
  input wire logic [1:0]  irqLevel,
  input wire logic [6:0]  resetCause,
  input wire logic [15:0] irqVector, trapVector, resetVector
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  rst_default_a: assert property (resetReq |-> reqFlags == 51'h0 && &maskFlags
    && &levelBit0Flags && &levelBit1Flags) else $error("flags not defaulted");
  mask_gate_a: assert property (irqReq |-> reqFlags[irqIndex] && !maskFlags[irqIndex])
    else $error("masked or idle slot presented");
  enable_gate_a: assert property (irqReq |-> $past(globalIrqEnable))
    else $error("request presented while disabled");
  rank_gate_a: assert property (irqReq |->
    irqLevel == {levelBit1Flags[irqIndex], levelBit0Flags[irqIndex]}
    && irqLevel <= {$past(inServiceLevelBit1), $past(inServiceLevelBit0)})
    else $error("level not ranked");
  vec_last_a: assert property (irqReq && irqIndex == 6'd50 |-> irqVector == 16'h0072)
    else $error("wrong vector for slot 50");
  trap_set_a: assert property (softwareTrapInstruction |=> trapReq
    && trapVector == 16'h007E) else $error("trap not raised");
  opc_reset_a: assert property (opcodeExec && opcodeByte == 8'hFF && !debugMode
    |=> resetReq && resetCause[4] && resetVector == 16'h0000) else $error("no opcode reset");
  dbg_block_a: assert property (resetCause[4] |-> $past(opcodeExec)
    && $past(opcodeByte) == 8'hFF && !$past(debugMode)) else $error("opcode reset uncaused");
  volt_mode_a: assert property (voltageDetect && detectionLevelReg[7]
    |=> resetReq && resetCause[2]) else $error("voltage reset missing");
  cover property (irqReq && irqIndex == 6'd50);
  cover property (trapReq);
  cover property (resetReq && resetCause[2]);
endmodule
bind isfm_core isfm_core_asserts u_isfm_core_asserts (.ref_clk, .reset_n, .globalIrqEnable,
  .debugMode, .opcodeExec, .voltageDetect, .softwareTrapInstruction, .irqReq, .trapReq,
  .resetReq, .inServiceLevelBit0, .inServiceLevelBit1, .opcodeByte, .detectionLevelReg,
  .reqFlags, .maskFlags, .levelBit0Flags, .levelBit1Flags, .irqIndex, .irqLevel,
  .resetCause, .irqVector, .trapVector, .resetVector);
`default_nettype wire

// *** sim/test_isfm_core.sv ***
// self-checking bench for the interrupt source flag map
`default_nettype none
module test_isfm_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, reset_n, ackOn, irqAck, trapAck, ge, in_service_level_bit0, in_service_level_bit1, dbg, opEx, trap;
  logic        wrEn, wrD, irqReq, trapReq, resetReq;
  logic [1:0]  wrSel, irqLevel;
  logic [5:0]  wrIdx, irqIndex;
  logic [23:0] ev;
  logic [50:0] pr, reqFlags, maskFlags, lvl0, lvl1;
  logic [7:0]  pin, rise, fall, dl, opB;
  logic [15:0] irqVector, trapVector, resetVector;
  logic [6:0]  resetCause;
  int          err_total = 0, check_count = 0, cycles = 0;
  int          slot [18] = '{8, 8, 8, 11, 11, 11, 15, 15, 15,
                             14, 14, 17, 17, 19, 19, 24, 24, 50};
  int          cause [6] = '{0, 1, 2, 3, 5, 6};
  isfm_core u_isfm_core (.ref_clk(ref_clk), .reset_n(reset_n), .periphReq(pr),
    .serial2TxEndIrq(ev[0]), .serial2ClockedEndIrq(ev[1]), .serial2SimpleI2cIrq(ev[2]),
    .serial0TxEndIrq(ev[3]), .serial0ClockedEndIrq(ev[4]), .serial0SimpleI2cIrq(ev[5]),
    .serial1TxEndIrq(ev[6]), .serial1ClockedEndIrq(ev[7]), .serial1SimpleI2cIrq(ev[8]),
    .uart0RxErrorIrq(ev[9]), .timerCh1UpperIrq(ev[10]), .uart1RxErrorIrq(ev[11]),
    .timerCh3UpperIrq(ev[12]), .clockCorrectionIrq(ev[13]), .samplingDetect0Irq(ev[14]),
    .clockPeriodicAlarmIrq(ev[15]), .samplingDetect1Irq(ev[16]), .extraUartRxErrorIrq(ev[17]),
    .extPin(pin), .riseEdgeEnableReg(rise), .fallEdgeEnableReg(fall), .detectionLevelReg(dl),
    .voltageDetect(ev[20]), .resetPin(ev[18]), .powerOnReset(ev[19]),
    .watchdogOverflow(ev[21]), .illegalAccessReset(ev[22]), .ramParityReset(ev[23]),
    .opcodeExec(opEx), .opcodeByte(opB), .debugMode(dbg), .softwareTrapInstruction(trap),
    .trapAck(trapAck), .globalIrqEnable(ge), .inServiceLevelBit0(in_service_level_bit0),
    .inServiceLevelBit1(in_service_level_bit1), .irqAck(irqAck), .flagWrEn(wrEn), .flagWrSel(wrSel),
    .flagWrIdx(wrIdx), .flagWrData(wrD), .reqFlags(reqFlags), .maskFlags(maskFlags),
    .levelBit0Flags(lvl0), .levelBit1Flags(lvl1), .irqReq(irqReq), .irqVector(irqVector),
    .irqLevel(irqLevel), .irqIndex(irqIndex), .trapReq(trapReq), .trapVector(trapVector),
    .resetReq(resetReq), .resetCause(resetCause), .resetVector(resetVector));
  isfm_cpu_model u_isfm_cpu_model (.ref_clk(ref_clk), .reset_n(reset_n), .ackOn(ackOn),
    .irqReq(irqReq), .trapReq(trapReq), .irqAck(irqAck), .trapAck(trapAck));
  task automatic cyc;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [5:0] i, input logic d);
    {wrSel, wrIdx, wrD, wrEn} = {s, i, d, 1'b1};
    cyc;
    wrEn = 1'b0;
    cyc;
  endtask
  task automatic pl(input int i);
    ev[i] = 1'b1;
    cyc;
    ev = '0;
  endtask
  task automatic pp(input logic [50:0] v);
    pr = v;
    cyc;
    pr = '0;
    cyc;
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // a full run needs about 140 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      report_and_stop;
    end
  end
  initial begin
    {ackOn, ge, in_service_level_bit0, in_service_level_bit1, dbg, opEx, trap, wrEn, wrD, wrSel, wrIdx} = '0;
    {ev, pr, pin, rise, fall, dl, opB} = '0;
    reset_n = 1'b0;
    repeat (20) cyc;
    reset_n = 1'b1;
    chk({reqFlags, &maskFlags, &lvl0, &lvl1}, {51'h0, 3'h7});
    // one shared source at a time, never two users of one slot
    foreach (slot[i]) begin
      pl(i);
      chk(reqFlags, 51'h1 << slot[i]);
      wr(2'h0, slot[i], 1'b0);
    end
    wr(2'h1, 6'd12, 1'b0);
    wr(2'h1, 6'd13, 1'b0);
    {ge, in_service_level_bit0, in_service_level_bit1} = 3'h7;
    pp(51'h3 << 12);
    chk({irqReq, irqIndex, irqVector, irqLevel}, {1'b1, 6'd12, 16'h0020, 2'h3});
    wr(2'h2, 6'd13, 1'b0);
    wr(2'h3, 6'd13, 1'b0);
    chk({irqReq, irqIndex, irqVector, irqLevel}, {1'b1, 6'd13, 16'h0022, 2'h0});
    ackOn = 1'b1;
    repeat (6) cyc;
    chk({irqReq, reqFlags[13:12]}, 3'h0);
    ackOn = 1'b0;
    wr(2'h1, 6'd13, 1'b1);
    pp(51'h1 << 13);
    chk({irqReq, reqFlags[13]}, 2'h1);
    wr(2'h1, 6'd13, 1'b0);
    chk({irqReq, irqIndex}, {1'b1, 6'd13});
    ge = 1'b0;
    cyc;
    chk(irqReq, 1'b0);
    wr(2'h0, 6'd13, 1'b0);
    ge = 1'b1;
    wr(2'h1, 6'd50, 1'b0);
    pl(17);
    chk({irqReq, irqIndex, irqVector}, {1'b1, 6'd50, 16'h0072});
    {in_service_level_bit0, in_service_level_bit1} = 2'h0;
    cyc;
    chk(irqReq, 1'b0);
    {ge, trap} = 2'h1;
    cyc;
    trap = 1'b0;
    chk({trapReq, trapVector}, {1'b1, 16'h007E});
    ackOn = 1'b1;
    repeat (3) cyc;
    chk(trapReq, 1'b0);
    {rise, pin} = {8'h01, 8'h01};
    repeat (2) cyc;
    chk(reqFlags[2], 1'b1);
    pin = 8'h00;
    wr(2'h0, 6'd2, 1'b0);
    repeat (2) cyc;
    chk(reqFlags[2], 1'b0);
    pl(20);
    chk({resetReq, reqFlags[1]}, 2'h1);
    dl = 8'h80;
    foreach (cause[i]) begin
      wr(2'h1, 6'd0, 1'b0);
      pl(18 + i);
      chk({resetReq, resetCause, resetVector, maskFlags[0]},
          {1'b1, 7'h1 << cause[i], 17'h1});
      cyc;
    end
    {opB, opEx} = {8'hFF, 1'b1};
    cyc;
    opEx = 1'b0;
    chk({resetReq, resetCause}, {1'b1, 7'h10});
    cyc;
    {dbg, opEx} = 2'h3;
    cyc;
    opEx = 1'b0;
    chk(resetReq, 1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire
